// file: bench/port_master_model.sv
// Purpose: bus master on port b
// Assumes: requests come from the bench one cycle ahead
// Notes: idle data lines toggle so a stale word never looks valid
`timescale 1ns/1ps
`default_nettype none
module port_master_model
	import dpram_pkg::*;
(
	// requests
	input wire logic sys_clk,
	input wire port_ctrl_s reqCtrl,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqData,
	// port pins
	output var port_ctrl_s ctrl,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] dataOut,
	output logic stageSelect
);
	assign stageSelect = 1'b1;
	initial begin
		ctrl = 8'hFF;
		addr = '0;
		dataOut = '0;
	end
	// requests are taken at the edge and shown just after it, so the bench never races us
	always @(posedge sys_clk) begin
		ctrl <= #1 reqCtrl;
		addr <= #1 reqAddr;
		dataOut <= #1 (reqCtrl.writeN ? ~dataOut : reqData);
	end
endmodule
`default_nettype wire

// file: bench/ram_checker_properties.sv
// Purpose: port timing checks
// Assumes: clkEn high, port a flow-through, port b pipelined
// Notes: flow-through shows two edges after the taking edge, pipelined three
`timescale 1ns/1ps
`default_nettype none
module ram_checker
	import dpram_pkg::*;
(
	// clock
	input wire logic sys_clk,
	input wire logic rst,
	// pins
	input wire port_ctrl_s ctrlA,
	input wire port_ctrl_s ctrlB,
	input wire logic outputDriveNA,
	input wire logic output_stage_selectA,
	input wire logic output_stage_selectB,
	input wire logic [DATA_W-1:0] dataOutA,
	input wire logic [1:0] dataOutEnA,
	input wire logic [1:0] dataOutEnB
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	wire logic flowA = !output_stage_selectA;
	wire logic rdA = flowA && !ctrlA.selectActiveLow && ctrlA.selectActiveHigh && ctrlA.writeN;
	// a write on port b could change the held word, so it must be quiet
	wire logic holdA = rdA && ctrlA.addressLoadStrobeN && ctrlA.countAdvanceN
		&& ctrlA.countClearN && ctrlB.writeN;
	AST_SELLOW_A: assert property (flowA && ctrlA.selectActiveLow |-> ##2 !dataOutEnA)
		else $error("a on after deselect");
	AST_SELHIGH_A: assert property (flowA && !ctrlA.selectActiveHigh |-> ##2 !dataOutEnA)
		else $error("a on after high select low");
	AST_LANE_A: assert property (flowA && ctrlA.upperLaneSelectN && ctrlA.lowerLaneSelectN
		|-> ##2 !dataOutEnA) else $error("a on with no lanes");
	AST_UP_A: assert property (rdA && !ctrlA.upperLaneSelectN && ctrlA.lowerLaneSelectN
		##1 !outputDriveNA |-> ##1 dataOutEnA == 2'h2) else $error("upper lane only wrong");
	AST_LO_A: assert property (rdA && ctrlA.upperLaneSelectN && !ctrlA.lowerLaneSelectN
		##1 !outputDriveNA |-> ##1 dataOutEnA == 2'h1) else $error("lower lane only wrong");
	AST_DRV_A: assert property (outputDriveNA |-> ##1 !dataOutEnA)
		else $error("a drives while disabled");
	AST_HOLD_A: assert property (holdA [*2] |-> ##2 $stable(dataOutA))
		else $error("held read changed");
	// double registering keeps the lanes dark for both edges after one deselected cycle
	AST_DESEL_B: assert property (output_stage_selectB && ctrlB.selectActiveLow
		|-> ##2 dataOutEnB == OE_OFF ##1 dataOutEnB == OE_OFF)
		else $error("b on after deselect");
endmodule
bind sync_dual_port_ram ram_checker portChecks (.sys_clk(sys_clk), .rst(rst), .ctrlA(ctrlA),
	.ctrlB(ctrlB), .outputDriveNA(outputDriveNA), .output_stage_selectA(output_stage_selectA),
	.output_stage_selectB(output_stage_selectB), .dataOutA(dataOutA),
	.dataOutEnA(dataOutEnA), .dataOutEnB(dataOutEnB));
`default_nettype wire

// file: bench/testbench.sv
// Purpose: self-checking bench for the dual-port ram
// Assumes: port a flow-through from the bench, port b pipelined
// Notes: rows run back to back; cross-port cases follow
`timescale 1ns/1ps
`default_nettype none
module testbench
	import dpram_pkg::*;
;
	typedef struct packed {
		logic [7:0] c;
		logic [3:0] a;
		logic [15:0] d;
		logic chk;
		logic [1:0] en;
		logic [15:0] q;
	} row_s;
	row_s rows [15] = '{'{8'h43, 4'h3, 16'hA5C3, 1'b0, 2'h0, 16'h0},
		'{8'h43, 4'h4, 16'h1234, 1'b0, 2'h0, 16'h0}, '{8'h4B, 4'h3, 16'h0, 1'b1, 2'h3, 16'hA5C3},
		'{8'h4D, 4'h0, 16'h0, 1'b1, 2'h3, 16'h1234}, '{8'h4F, 4'h0, 16'h0, 1'b1, 2'h3, 16'h1234},
		'{8'h4F, 4'h0, 16'h0, 1'b1, 2'h3, 16'h1234}, '{8'h5B, 4'h3, 16'h0, 1'b1, 2'h2, 16'hA5C3},
		'{8'h6B, 4'h3, 16'h0, 1'b1, 2'h1, 16'hA5C3}, '{8'h53, 4'h3, 16'h7700, 1'b0, 2'h0, 16'h0},
		'{8'h4B, 4'h3, 16'h0, 1'b1, 2'h3, 16'h77C3}, '{8'hCB, 4'h3, 16'h0, 1'b1, 2'h0, 16'h0},
		'{8'h42, 4'h5, 16'h0F0F, 1'b0, 2'h0, 16'h0}, '{8'h4B, 4'h0, 16'h0, 1'b1, 2'h3, 16'h0F0F},
		'{8'h0B, 4'h3, 16'h0, 1'b1, 2'h0, 16'h0}, '{8'h7B, 4'h3, 16'h0, 1'b1, 2'h0, 16'h0}};
	logic sys_clk = 0, rst = 1, driveNA = 0, stageB;
	port_ctrl_s ctrlA = 8'hFF, reqB = 8'hFF, ctrlB;
	logic [ADDR_W-1:0] addrA = '0, reqAddrB = '0, addrB;
	logic [DATA_W-1:0] dinA = '0, reqDataB = '0, dinB, dataOutA, dataOutB;
	logic [1:0] dataOutEnA, dataOutEnB;
	int badCount = 0, comparisons = 0;
	sync_dual_port_ram #(.DEPTH(16)) DUT (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1),
		.ctrlA(ctrlA), .addrA(addrA), .dataInA(dinA), .outputDriveNA(driveNA),
		.output_stage_selectA(1'b0), .dataOutA(dataOutA), .dataOutEnA(dataOutEnA),
		.ctrlB(ctrlB), .addrB(addrB), .dataInB(dinB), .outputDriveNB(1'b0),
		.output_stage_selectB(stageB), .dataOutB(dataOutB), .dataOutEnB(dataOutEnB));
	port_master_model partner (.sys_clk(sys_clk), .reqCtrl(reqB), .reqAddr(reqAddrB),
		.reqData(reqDataB), .ctrl(ctrlB), .addr(addrB), .dataOut(dinB), .stageSelect(stageB));
	task automatic check(input logic ok, input string what);
		comparisons++;
		if (!ok) begin
			badCount++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic putA(input logic [7:0] c, input logic [3:0] a, input logic [15:0] d);
		ctrlA = c;
		addrA = ADDR_W'(a);
		dinA = d;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (400) @(posedge sys_clk);
		badCount++;
		conclude();
	end
	initial begin
		logic [15:0] m;
		tick(3);
		rst = 0;
		// flow-through word of row i shows two steps after it is driven
		for (int i = 0; i < 17; i++) begin
			if (i >= 2 && rows[i-2].chk) begin
				m = {{8{rows[i-2].en[1]}}, {8{rows[i-2].en[0]}}};
				check(dataOutEnA === rows[i-2].en, "lane drive");
				check((dataOutA & m) === (rows[i-2].q & m), "read word");
			end
			if (i < 15) putA(rows[i].c, rows[i].a, rows[i].d);
			else putA(8'hFF, 4'h0, 16'h0);
			tick(1);
		end
		driveNA = 1;
		putA(8'h4B, 4'h3, 16'h0);
		reqB = 8'h4B;
		reqAddrB = ADDR_W'(3);
		tick(3);
		check(dataOutEnA === OE_OFF, "drive off");
		driveNA = 0;
		putA(8'h43, 4'h9, 16'h5A5A);
		reqAddrB = ADDR_W'(9);
		tick(1);
		putA(8'hFF, 4'h0, 16'h0);
		tick(2);
		check(dataOutB === 16'h77C3, "pipelined too early");
		tick(1);
		check(dataOutB === 16'h5A5A && dataOutEnB === OE_BOTH, "cross read");
		reqB = 8'h43;
		reqAddrB = ADDR_W'(10);
		reqDataB = 16'hC3C3;
		tick(2);
		reqB = 8'hCB;
		putA(8'h4B, 4'hA, 16'h0);
		tick(3);
		check(dataOutA === 16'hC3C3, "b to a write");
		tick(3);
		check(dataOutEnB === OE_OFF, "b deselect");
		// read, idle cycle, write: the word is then written once more before use
		putA(8'h4B, 4'hB, 16'h0);
		tick(1);
		putA(8'hCB, 4'hB, 16'h0);
		tick(1);
		putA(8'h43, 4'hB, 16'h1357);
		tick(1);
		putA(8'h43, 4'hB, 16'h1357);
		tick(1);
		putA(8'h4B, 4'hB, 16'h0);
		tick(3);
		check(dataOutA === 16'h1357 && dataOutEnA === OE_BOTH, "rewrite after idle");
		rst = 1;
		tick(1);
		check(dataOutEnA === OE_OFF && dataOutA === DATA_ZERO, "reset state");
		rst = 0;
		tick(1);
		conclude();
	end
endmodule
`default_nettype wire

// file: include/dpram_pkg.sv
// Purpose: shared constants and carriers for the dual-port synchronous ram
// Assumes: one system clock drives both ports
// Notes: widths here are fixed; the top module overrides only DEPTH
package dpram_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	localparam logic [14:0] ADDR_ZERO = 15'h0000;
	localparam logic [15:0] DATA_ZERO = 16'h0000;
	localparam logic [1:0] OE_OFF = 2'h0;
	localparam logic [1:0] OE_BOTH = 2'h3;
	// port-to-port timing, ns, fastest grade
	localparam int WRITE_TO_READ_NS = 35;
	localparam int CLOCK_OFFSET_NS = 15;
	localparam int CLK_PERIOD_NS = 100;
	// longest time rounds down, but never below one cycle
	localparam int WRITE_TO_READ_CYC =
		(WRITE_TO_READ_NS / CLK_PERIOD_NS) < 1 ? 1 : (WRITE_TO_READ_NS / CLK_PERIOD_NS);

	// one port's synchronous controls, all sampled on the clock edge
	typedef struct packed {
		logic selectActiveLow;
		logic selectActiveHigh;
		logic upperLaneSelectN;
		logic lowerLaneSelectN;
		logic writeN;
		logic addressLoadStrobeN;
		logic countAdvanceN;
		logic countClearN;
	} port_ctrl_s;
endpackage

// file: verilog/dpram_port.sv
// Purpose: one port's address counter, control registers and output stage
// Assumes: storage lives in the parent; both ports share this module
// Notes: output drive and stage select act without the clock
`timescale 1ns/1ps
`default_nettype none
module dpram_port
	import dpram_pkg::*;
(
	// clock
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	// port pins
	input wire port_ctrl_s ctrl,
	input wire logic [ADDR_W-1:0] extAddr,
	input wire logic [DATA_W-1:0] dataIn,
	input wire logic outputDriveN,
	input wire logic outputStageSelect,
	// array side
	output logic [ADDR_W-1:0] accessAddr,
	output logic writeStrobe,
	output logic [1:0] writeLanes,
	output logic [DATA_W-1:0] writeData,
	input wire logic [DATA_W-1:0] readWord,
	// data pins
	output logic [DATA_W-1:0] dataOut,
	output logic [1:0] dataOutEn
);
	logic [ADDR_W-1:0] counter;
	logic [DATA_W-1:0] flowData;
	logic [DATA_W-1:0] pipeData;
	logic selReg1;
	logic selReg2;
	logic [1:0] laneReg1;
	logic [1:0] laneReg2;
	logic readReg1;
	logic readReg2;

	// ------------------------------------------------------------
	// address selection
	// ------------------------------------------------------------
	wire chipSelected = !ctrl.selectActiveLow && ctrl.selectActiveHigh;
	wire [1:0] laneOn = {!ctrl.upperLaneSelectN, !ctrl.lowerLaneSelectN};
	// clear wins over load and advance, and addresses word zero this cycle
	wire [ADDR_W-1:0] next_addr = !ctrl.countClearN ? ADDR_ZERO : // see R15
		!ctrl.addressLoadStrobeN ? extAddr : // see R6
		!ctrl.countAdvanceN ? ADDR_W'(counter + 1'b1) : counter; // see R14 see R7

	assign accessAddr = next_addr;
	assign writeStrobe = clkEn && chipSelected && !ctrl.writeN && (laneOn != 2'h0);
	assign writeLanes = laneOn;
	assign writeData = dataIn;

	// ------------------------------------------------------------
	// registers, all on the rising edge
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin // see R1
		if (rst) begin
			counter <= ADDR_ZERO;
			flowData <= DATA_ZERO;
			pipeData <= DATA_ZERO;
			selReg1 <= 1'b0;
			selReg2 <= 1'b0;
			laneReg1 <= OE_OFF;
			laneReg2 <= OE_OFF;
			readReg1 <= 1'b0;
			readReg2 <= 1'b0;
		end else if (clkEn) begin
			counter <= next_addr;
			flowData <= readWord;
			pipeData <= flowData; // see R12
			selReg1 <= chipSelected;
			selReg2 <= selReg1; // see R13
			laneReg1 <= laneOn;
			laneReg2 <= laneReg1;
			readReg1 <= ctrl.writeN;
			readReg2 <= readReg1;
		end
	end

	// ------------------------------------------------------------
	// output stage: state comes from the previous cycle's controls in flow-through, from the last two cycles' in pipelined
	// ------------------------------------------------------------
	// lanes and reads take one register in flow-through, two in pipelined; selects need both in pipelined
	wire selNow = outputStageSelect ? (selReg1 && selReg2) : selReg1; // see R13 see R3
	wire readNow = outputStageSelect ? readReg2 : readReg1; // see R8
	wire [1:0] laneNow = outputStageSelect ? laneReg2 : laneReg1;
	wire [1:0] driveNow = (selNow && readNow && !outputDriveN) ? laneNow : OE_OFF; // see R4 see R5

	// the parent registers these so its outputs come from flip-flops
	assign dataOut = outputStageSelect ? pipeData : flowData; // see R3 see R12
	assign dataOutEn = driveNow;
endmodule
`default_nettype wire

// file: verilog/sync_dual_port_ram.sv
// Purpose: synchronous dual-port static ram with per-port output timing
// Assumes: both ports on sys_clk; other party keeps stage select static
// Notes: a write-to-read collision returns the new word one cycle later
`timescale 1ns/1ps
`default_nettype none
// Rules for this block and its controller
// R1: inputs captured on clock, drive and stage async; here both reach the pins one cycle late through the output flops
// R2: controller keeps stage select static
// R3: stage select high pipelined, low flow-through
// R4: deselect or no lanes floats outputs
// R5: a deselected lane floats alone
// R6: load strobe low loads external address
// R7: strobe and advance high hold address
// R8: output state from previous cycle controls; at the pins here it trails by one more cycle through the output flops
// R9: controller rewrites data after read-write nop
// R10: reader waits write-to-read delay across ports
// R11: both ports share identical timing
// R12: pipelined data one cycle after flow-through
// R13: pipelined selects double registered
// R14: advance low increments counter unless clear or load is low
// R15: clear low uses address zero
module sync_dual_port_ram
	import dpram_pkg::*;
#(
	parameter int DEPTH = 32768
)(
	// clock
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	// port a
	input wire port_ctrl_s ctrlA,
	input wire logic [ADDR_W-1:0] addrA,
	input wire logic [DATA_W-1:0] dataInA,
	input wire logic outputDriveNA,
	input wire logic output_stage_selectA,
	output logic [DATA_W-1:0] dataOutA,
	output logic [1:0] dataOutEnA,
	// port b
	input wire port_ctrl_s ctrlB,
	input wire logic [ADDR_W-1:0] addrB,
	input wire logic [DATA_W-1:0] dataInB,
	input wire logic outputDriveNB,
	input wire logic output_stage_selectB,
	output logic [DATA_W-1:0] dataOutB,
	output logic [1:0] dataOutEnB
);
	// a depth that is not a power of two would let the cut index run past the last word
	if (DEPTH < 2 || DEPTH > (1 << ADDR_W) || (DEPTH & (DEPTH - 1)) != 0) begin
		$error("DEPTH out of range");
	end

	logic [DATA_W-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] addrIntA;
	logic [ADDR_W-1:0] addrIntB;
	logic weA;
	logic weB;
	logic [1:0] lanesA;
	logic [1:0] lanesB;
	logic [DATA_W-1:0] wdA;
	logic [DATA_W-1:0] wdB;
	logic [DATA_W-1:0] rdA;
	logic [DATA_W-1:0] rdB;
	logic [DATA_W-1:0] portOutA;
	logic [DATA_W-1:0] portOutB;
	logic [1:0] portEnA;
	logic [1:0] portEnB;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nw, input logic [1:0] lanes);
		merge = {lanes[1] ? nw[DATA_W-1:LANE_W] : old[DATA_W-1:LANE_W],
			lanes[0] ? nw[LANE_W-1:0] : old[LANE_W-1:0]};
	endfunction

	// ------------------------------------------------------------
	// two identical ports
	// ------------------------------------------------------------
	dpram_port portA ( // see R11
		.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
		.ctrl(ctrlA), .extAddr(addrA), .dataIn(dataInA),
		.outputDriveN(outputDriveNA), .outputStageSelect(output_stage_selectA),
		.accessAddr(addrIntA), .writeStrobe(weA), .writeLanes(lanesA),
		.writeData(wdA), .readWord(rdA), .dataOut(portOutA), .dataOutEn(portEnA)
	);
	dpram_port portB ( // see R11
		.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
		.ctrl(ctrlB), .extAddr(addrB), .dataIn(dataInB),
		.outputDriveN(outputDriveNB), .outputStageSelect(output_stage_selectB),
		.accessAddr(addrIntB), .writeStrobe(weB), .writeLanes(lanesB),
		.writeData(wdB), .readWord(rdB), .dataOut(portOutB), .dataOutEn(portEnB)
	);

	// ------------------------------------------------------------
	// array: read returns old word; the other port sees a write next cycle
	// ------------------------------------------------------------
	// same-cycle writes to one word: port b lanes land last, no arbitration
	wire [ADDR_W-1:0] idxA = addrIntA;
	wire [ADDR_W-1:0] idxB = addrIntB;
	assign rdA = mem[idxA[$clog2(DEPTH)-1:0]];
	assign rdB = mem[idxB[$clog2(DEPTH)-1:0]]; // see R10

	always_ff @(posedge sys_clk) begin
		if (weA)
			mem[idxA[$clog2(DEPTH)-1:0]] <= merge(rdA, wdA, lanesA);
		if (weB)
			mem[idxB[$clog2(DEPTH)-1:0]] <= merge(weA && idxA == idxB ?
				merge(rdA, wdA, lanesA) : rdB, wdB, lanesB);
	end

	// ------------------------------------------------------------
	// output flops; enables follow outputDriveN one cycle later
	// ------------------------------------------------------------
	// trade-off: registering outputs delays the async drive control by a cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dataOutA <= DATA_ZERO;
			dataOutB <= DATA_ZERO;
			dataOutEnA <= OE_OFF;
			dataOutEnB <= OE_OFF;
		end else if (clkEn) begin
			dataOutA <= portOutA;
			dataOutB <= portOutB;
			dataOutEnA <= portEnA; // see R4 see R5
			dataOutEnB <= portEnB;
		end
	end
endmodule
`default_nettype wire
